// >>> design/efh_pkg.sv
// Constants shared by the framer and data-link event logic.
package efh_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [15:0] FRAMER_STATUS_ADDR = 16'h0B04;
	localparam logic [15:0] FRAMER_MASK_ADDR   = 16'h0B10;
	localparam logic [15:0] LINK1_STATUS_ADDR  = 16'h0B14;
	localparam logic [15:0] LINK1_MASK_ADDR    = 16'h0B18;
	localparam logic [15:0] FRAMER_CTRL_ADDR   = 16'h0B1C;
	localparam int          ADDR_W             = 16;
	localparam int          WORD_LSB           = 2;

	// Framer event bit positions, shared by status and enable.
	localparam int FR_EVENTS     = 4;
	localparam int FR_LOSS_BIT   = 3;
	localparam int FR_MIMIC_BIT  = 2;
	localparam int FR_CRC4_BIT   = 1;
	localparam int FR_ALIGN_BIT  = 0;

	// Data-link status bit positions.
	localparam int LK_EVENTS     = 7;
	localparam int LK_KIND_BIT   = 7;
	localparam int LK_TX_ST_BIT  = 6;
	localparam int LK_RX_ST_BIT  = 5;
	localparam int LK_TX_END_BIT = 4;
	localparam int LK_RX_END_BIT = 3;
	localparam int LK_FCS_BIT    = 2;
	localparam int LK_ABORT_BIT  = 1;
	localparam int LK_IDLE_BIT   = 0;
	localparam int LK_MASK_MSB   = 6;
	localparam int LK_MASK_LSB   = 3;
	localparam int LK_MASK_W     = 4;

	// Reset values.
	localparam logic [3:0] FR_MASK_RESET  = 4'h0;
	localparam logic [3:0] LK_MASK_RESET  = 4'h0;
	localparam logic [2:0] CRITERIA_RESET = 3'h3;
	localparam int         CRIT_W         = 3;
	localparam int         CRIT_LSB       = 0;

	// Data-link channel patterns.
	localparam logic [7:0] FLAG_OCTET     = 8'h7E;
	localparam logic [2:0] ABORT_RUN_LAST = 3'h6;
	localparam logic [2:0] ABORT_RUN_MAX  = 3'h7;

	typedef enum logic {
		EFH_IN_FRAME,
		EFH_OUT_OF_FRAME
	} efh_align_state_type;

endpackage : efh_pkg

// >>> design/efh_event_latch.sv
// Bank of sticky event bits that clear when their register is read.
`timescale 1ns/10ps
module efh_event_latch #(
	parameter int WIDTH = 4
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] event_in,
	input  wire logic             read_clear_in,
	output logic      [WIDTH-1:0] status_out
);

	////////////////////////////////////////////////////////////////////
	// An event in the clearing cycle survives, so a read never hides it.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					status_out[i] <= 1'b0;
				end else if (event_in[i]) begin
					status_out[i] <= 1'b1;
				end else if (read_clear_in) begin
					status_out[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : efh_event_latch

// >>> design/efh_frame_loss.sv
// Out-of-frame defect tracker driven by frame alignment checks.
`timescale 1ns/10ps
module efh_frame_loss (
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       fas_checked_in,
	input  wire logic       fas_errored_in,
	input  wire logic [2:0] criteria_in,
	output logic            defect_out,
	output logic            change_out
);

	efh_pkg::efh_align_state_type state_reg;
	efh_pkg::efh_align_state_type state_next;
	logic [2:0]                   err_cnt_reg;
	logic [2:0]                   err_cnt_next;
	logic                         change_next;
	logic [3:0]                   err_run;

	assign err_run = {1'b0, err_cnt_reg} + 4'h1;

	////////////////////////////////////////////////////////////////////
	// A criteria of zero declares on the first errored pattern.
	always_comb begin
		state_next   = state_reg;
		err_cnt_next = err_cnt_reg;
		change_next  = 1'b0;
		case (state_reg)
			efh_pkg::EFH_IN_FRAME: begin
				if (fas_checked_in && fas_errored_in) begin
					if (err_run >= {1'b0, criteria_in}) begin
						state_next   = efh_pkg::EFH_OUT_OF_FRAME;
						err_cnt_next = 3'h0;
						change_next  = 1'b1;
					end else begin
						err_cnt_next = err_run[2:0];
					end
				end else if (fas_checked_in) begin
					err_cnt_next = 3'h0;
				end
			end
			efh_pkg::EFH_OUT_OF_FRAME: begin
				if (fas_checked_in && !fas_errored_in) begin
					state_next  = efh_pkg::EFH_IN_FRAME;
					change_next = 1'b1;
				end
			end
			default: begin
				state_next = efh_pkg::EFH_IN_FRAME;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg   <= efh_pkg::EFH_IN_FRAME;
			err_cnt_reg <= 3'h0;
			change_out  <= 1'b0;
			defect_out  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			err_cnt_reg <= err_cnt_next;
			change_out  <= change_next;
			defect_out  <= (state_next == efh_pkg::EFH_OUT_OF_FRAME);
		end
	end

endmodule : efh_frame_loss

// >>> design/efh_irq_top.sv
// Framer and data-link event status, enables and interrupt request.
//
// Summary of operation
// - Frame-loss change interrupt fires when the defect is declared and cleared.
// - Frame-mimic detection raises an interrupt when enabled.
// - A CRC-4 mismatch in a sub-multiframe raises an interrupt when enabled.
// - Errored alignment bits interrupt; this does not imply loss of sync.
// - Framer enable bits are read/write, 1 allows, 0 suppresses, reset 0.
// - Message kind bit reads 0 for bit-oriented, 1 for message-oriented.
// - Data-link event bits latch at 1 and clear after being read.
// - Transmit-start bit sets when the transmitter begins a message.
// - Receive-start bit sets when the receiver begins a message.
// - Transmit-end bit sets when the transmitter finishes a message.
// - Receive-end bit sets on a complete message or a full buffer.
// - FCS error bit sets when the last received message fails its check.
// - Abort bit sets on seven consecutive ones in the link channel.
// - Idle bit sets on a flag octet in the link channel.
// - Link enables: bits 6 to 3 read/write, bit 7 reserved.
// - Framer events latch at their enable positions and clear on read.
// - Frame loss is declared after a programmed run of errored patterns.
`timescale 1ns/10ps
module efh_irq_top (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [15:0] paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        fas_checked_in,
	input  wire logic        fas_errored_in,
	input  wire logic        frame_mimic_in,
	input  wire logic        crc4_error_in,
	input  wire logic        tx_message_started_in,
	input  wire logic        rx_message_started_in,
	input  wire logic        tx_message_finished_in,
	input  wire logic        rx_message_finished_in,
	input  wire logic        rx_buffer_full_in,
	input  wire logic        fcs_error_in,
	input  wire logic        link_message_kind_in,
	input  wire logic        link_bit_valid_in,
	input  wire logic        link_bit_in,
	output logic             frame_loss_defect_out,
	output logic             irq_out
);

	////////////////////////////////////////////////////////////////////
	// Declarations.

	localparam int FRN = efh_pkg::FR_EVENTS;
	localparam int LKN = efh_pkg::LK_EVENTS;
	localparam int MSB = efh_pkg::LK_MASK_MSB;
	localparam int LSB = efh_pkg::LK_MASK_LSB;
	localparam int CW  = efh_pkg::CRIT_W;
	localparam int CL  = efh_pkg::CRIT_LSB;
	localparam int ADDR_W = efh_pkg::ADDR_W - efh_pkg::WORD_LSB;

	logic [FRN-1:0]     fr_mask_reg;
	logic [MSB:LSB]     lk_mask_reg;
	logic [CW-1:0]      criteria_reg;
	logic               kind_reg;
	logic [FRN-1:0]     fr_status;
	logic [LKN-1:0]     lk_status;
	logic [FRN-1:0]     fr_event;
	logic [LKN-1:0]     lk_event;
	logic               loss_change;
	logic               loss_defect;
	logic [7:0]         shift_reg;
	logic [7:0]         shift_next;
	logic [2:0]         ones_reg;
	logic [2:0]         ones_next;
	logic               abort_seen;
	logic               flag_seen;
	logic               access;
	logic               first_access;
	logic               write_done;
	logic [ADDR_W-1:0]  word_addr;
	logic               hit_fr_status;
	logic               hit_fr_mask;
	logic               hit_lk_status;
	logic               hit_lk_mask;
	logic               hit_ctrl;
	logic               mapped;
	logic [31:0]        rd_data;
	logic               clr_fr;
	logic               clr_lk;
	logic               irq_next;

	////////////////////////////////////////////////////////////////////
	// APB decode. The slave inserts one wait state so that read data,
	// the error flag and the ready strobe all leave from flip-flops.
	// Each register is one byte alone in its word.
	// The framer status is sticky and a read clears it.
	// The framer enables sit in bits 3 to 0.
	// The link status has the kind in bit 7, events below.
	// The link enables sit in bits 6 to 3.
	// The criteria field sits in bits 2 to 0.
	// Writes to a status register are ignored.
	// Only an unmapped address answers with an error.

	assign access       = psel_in && penable_in;
	assign first_access = access && !pready_out;
	assign write_done   = access && pready_out && pwrite_in && pstrb_in[0];
	assign word_addr    = paddr_in[efh_pkg::ADDR_W-1:efh_pkg::WORD_LSB];

	assign hit_fr_status = word_addr ==
		efh_pkg::FRAMER_STATUS_ADDR[efh_pkg::ADDR_W-1:efh_pkg::WORD_LSB];
	assign hit_fr_mask = word_addr ==
		efh_pkg::FRAMER_MASK_ADDR[efh_pkg::ADDR_W-1:efh_pkg::WORD_LSB];
	assign hit_lk_status = word_addr ==
		efh_pkg::LINK1_STATUS_ADDR[efh_pkg::ADDR_W-1:efh_pkg::WORD_LSB];
	assign hit_lk_mask = word_addr ==
		efh_pkg::LINK1_MASK_ADDR[efh_pkg::ADDR_W-1:efh_pkg::WORD_LSB];
	assign hit_ctrl = word_addr ==
		efh_pkg::FRAMER_CTRL_ADDR[efh_pkg::ADDR_W-1:efh_pkg::WORD_LSB];

	assign mapped = hit_fr_status || hit_fr_mask || hit_lk_status ||
		hit_lk_mask || hit_ctrl;

	// Status clears at the same edge that captures read data, so an event
	// arriving later is kept for the next read rather than lost.
	assign clr_fr = first_access && !pwrite_in && hit_fr_status;
	assign clr_lk = first_access && !pwrite_in && hit_lk_status;

	////////////////////////////////////////////////////////////////////
	// Read data. Reserved and unused bits read as zero.
	// Read data is held until the next read, so a
	// late look at it still sees the same value.

	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_fr_status) begin
			rd_data[FRN-1:0] = fr_status;
		end else if (hit_fr_mask) begin
			rd_data[FRN-1:0] = fr_mask_reg;
		end else if (hit_lk_status) begin
			rd_data[LKN-1:0] = lk_status;
			rd_data[efh_pkg::LK_KIND_BIT] = kind_reg;
		end else if (hit_lk_mask) begin
			rd_data[MSB:LSB] = lk_mask_reg;
		end else if (hit_ctrl) begin
			rd_data[CL+CW-1:CL] = criteria_reg;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else begin
			// An unmapped access still ends after one wait
			// state, so a wrong address cannot stall the bus.
			pready_out  <= first_access;
			pslverr_out <= first_access && !mapped;
			if (first_access && !pwrite_in) begin
				prdata_out <= rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Software-written registers. A write lands at the completing edge.
	// Only byte lane 0 carries register bits, so a
	// write with its strobe low is dropped quietly.

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fr_mask_reg <= efh_pkg::FR_MASK_RESET;
		end else if (write_done && hit_fr_mask) begin
			fr_mask_reg <= pwdata_in[FRN-1:0];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lk_mask_reg <= efh_pkg::LK_MASK_RESET;
		end else if (write_done && hit_lk_mask) begin
			lk_mask_reg <= pwdata_in[MSB:LSB];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			criteria_reg <= efh_pkg::CRITERIA_RESET;
		end else if (write_done && hit_ctrl) begin
			criteria_reg <= pwdata_in[CL+CW-1:CL];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Message kind follows the receiver; a plain status, not sticky.
	// It describes the latest message received, so
	// latching it would report a stale kind.

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			kind_reg <= 1'b0;
		end else begin
			kind_reg <= link_message_kind_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data-link channel watcher for abort runs and flag octets.
	// Only valid bits move the watcher, so gaps in
	// the channel neither break a run nor a flag.
	// The run count saturates, so a long run of ones
	// cannot wrap and report a second abort.

	assign shift_next = {shift_reg[6:0], link_bit_in};

	always_comb begin
		ones_next = 3'h0;
		if (link_bit_in) begin
			if (ones_reg == efh_pkg::ABORT_RUN_MAX) begin
				ones_next = efh_pkg::ABORT_RUN_MAX;
			end else begin
				ones_next = ones_reg + 3'h1;
			end
		end
	end

	// The abort fires once, as the seventh one arrives; a longer run of
	// ones is a single abort, not one per bit.
	assign abort_seen = link_bit_valid_in && link_bit_in &&
		(ones_reg == efh_pkg::ABORT_RUN_LAST);
	assign flag_seen = link_bit_valid_in &&
		(shift_next == efh_pkg::FLAG_OCTET);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_reg <= 8'h00;
			ones_reg  <= 3'h0;
		end else if (link_bit_valid_in) begin
			shift_reg <= shift_next;
			ones_reg  <= ones_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frame-loss tracking.
	// A new criteria value applies at once, also to
	// a run of errored patterns already counted.

	efh_frame_loss u_frame_loss (
		.core_clk_in    (core_clk_in),
		.rst_n_in       (rst_n_in),
		.fas_checked_in (fas_checked_in),
		.fas_errored_in (fas_errored_in),
		.criteria_in    (criteria_reg),
		.defect_out     (loss_defect),
		.change_out     (loss_change)
	);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_loss_defect_out <= 1'b0;
		end else begin
			// Registered again so the defect leaves from a
			// flip-flop; it lags the tracker by one cycle.
			frame_loss_defect_out <= loss_defect;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Event collection. Enables play no part here, so polling works.
	// Each latch lets an event beat a read clear, so
	// an event in the clearing cycle is not lost.
	// Receive-end is set alike by a full message and
	// a full buffer; no status bit tells them apart.

	always_comb begin
		fr_event = '0;
		fr_event[efh_pkg::FR_LOSS_BIT]  = loss_change;
		fr_event[efh_pkg::FR_MIMIC_BIT] = frame_mimic_in;
		fr_event[efh_pkg::FR_CRC4_BIT]  = crc4_error_in;
		// A single errored alignment bit moves the defect state only at a criteria of 0 or 1.
		fr_event[efh_pkg::FR_ALIGN_BIT] =
			fas_checked_in && fas_errored_in;
	end

	always_comb begin
		lk_event = '0;
		lk_event[efh_pkg::LK_TX_ST_BIT]  = tx_message_started_in;
		lk_event[efh_pkg::LK_RX_ST_BIT]  = rx_message_started_in;
		lk_event[efh_pkg::LK_TX_END_BIT] = tx_message_finished_in;
		lk_event[efh_pkg::LK_RX_END_BIT] =
			rx_message_finished_in || rx_buffer_full_in;
		lk_event[efh_pkg::LK_FCS_BIT]    = fcs_error_in;
		lk_event[efh_pkg::LK_ABORT_BIT]  = abort_seen;
		lk_event[efh_pkg::LK_IDLE_BIT]   = flag_seen;
	end

	efh_event_latch #(
		.WIDTH (FRN)
	) u_framer_status (
		.core_clk_in   (core_clk_in),
		.rst_n_in      (rst_n_in),
		.event_in      (fr_event),
		.read_clear_in (clr_fr),
		.status_out    (fr_status)
	);

	efh_event_latch #(
		.WIDTH (LKN)
	) u_link_status (
		.core_clk_in   (core_clk_in),
		.rst_n_in      (rst_n_in),
		.event_in      (lk_event),
		.read_clear_in (clr_lk),
		.status_out    (lk_status)
	);

	////////////////////////////////////////////////////////////////////
	// Interrupt request. Only the link events that have an enable can
	// interrupt; FCS, abort and idle are visible by polling alone.
	// The request drops only when software reads the
	// status or clears the enable behind it.

	assign irq_next = (|(fr_status & fr_mask_reg)) ||
		(|(lk_status[MSB:LSB] & lk_mask_reg));

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= irq_next;
		end
	end

endmodule : efh_irq_top

// >>> verification/efh_irq_props.sv
// Checker for the framer and data-link event block at its ports.
`timescale 1ns/10ps
module efh_irq_props (
	input wire logic        core_clk_in,
	input wire logic        rst_n_in,
	input wire logic [15:0] paddr_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0]  pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        fas_checked_in,
	input wire logic        fas_errored_in,
	input wire logic        crc4_error_in,
	input wire logic        link_message_kind_in,
	input wire logic        frame_loss_defect_out,
	input wire logic        irq_out
);
	logic [3:0] fr_m;
	logic [3:0] lk_m;
	logic [2:0] crit;
	logic [2:0] run;
	wire        acc = psel_in & penable_in & pready_out;
	wire        wr  = acc & pwrite_in & pstrb_in[0] & ~pslverr_out;
	wire        rd  = acc & ~pwrite_in & ~pslverr_out;
	wire [3:0]  lim = (crit == 3'h0) ? 4'h1 : {1'b0, crit};
	wire        bad = fas_checked_in & fas_errored_in;
	wire        decide = bad & ({1'b0, run} + 4'h1 >= lim);
	////////////////////////////////////////////////////////////////////////
	// Shadows are rebuilt from observed writes, since the checker sees no
	// internal register.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fr_m <= 4'h0;
			lk_m <= 4'h0;
			crit <= 3'h3;
		end else if (wr && paddr_in == efh_pkg::FRAMER_MASK_ADDR) begin
			fr_m <= pwdata_in[3:0];
		end else if (wr && paddr_in == efh_pkg::LINK1_MASK_ADDR) begin
			lk_m <= pwdata_in[6:3];
		end else if (wr && paddr_in == efh_pkg::FRAMER_CTRL_ADDR) begin
			crit <= pwdata_in[2:0];
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run <= 3'h0;
		end else if (fas_checked_in) begin
			run <= !fas_errored_in ? 3'h0 : (run == 3'h7) ? run : run + 3'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	property p_crc_irq;
		crc4_error_in && fr_m[1] |-> ##2 irq_out;
	endproperty
	a_crc_irq: assert property (p_crc_irq) else $error("no crc irq");
	property p_quiet;
		fr_m == 4'h0 && lk_m == 4'h0 && $past(fr_m) == 4'h0
			&& $past(lk_m) == 4'h0 |-> !irq_out;
	endproperty
	a_quiet: assert property (p_quiet) else $error("masked irq");
	property p_kind;
		rd && paddr_in == efh_pkg::LINK1_STATUS_ADDR
			|-> prdata_out[7] == $past(link_message_kind_in, 2);
	endproperty
	a_kind: assert property (p_kind) else $error("kind bit wrong");
	property p_lk_rsvd;
		rd && paddr_in == efh_pkg::LINK1_MASK_ADDR
			|-> prdata_out[31:7] == 25'h0 && prdata_out[2:0] == 3'h0;
	endproperty
	a_lk_rsvd: assert property (p_lk_rsvd) else $error("mask bits");
	property p_fr_width;
		rd && paddr_in == efh_pkg::FRAMER_STATUS_ADDR
			|-> prdata_out[31:4] == 28'h0;
	endproperty
	a_fr_width: assert property (p_fr_width) else $error("fr bits");
	property p_lk_width;
		rd && paddr_in == efh_pkg::LINK1_STATUS_ADDR
			|-> prdata_out[31:8] == 24'h0;
	endproperty
	a_lk_width: assert property (p_lk_width) else $error("lk bits");
	property p_loss_set;
		decide |-> ##[1:3] frame_loss_defect_out;
	endproperty
	a_loss_set: assert property (p_loss_set) else $error("no loss");
	property p_loss_clr;
		fas_checked_in && !fas_errored_in |-> ##[1:3] !frame_loss_defect_out;
	endproperty
	a_loss_clr: assert property (p_loss_clr) else $error("loss held");
	property p_loss_irq;
		$changed(frame_loss_defect_out) && fr_m[3] |-> ##[0:2] irq_out;
	endproperty
	a_loss_irq: assert property (p_loss_irq) else $error("no loss irq");
	c_irq: cover property ($rose(irq_out));
	c_loss: cover property ($rose(frame_loss_defect_out));
	c_err: cover property (pslverr_out);
endmodule : efh_irq_props
bind efh_irq_top efh_irq_props efh_irq_props_i (.core_clk_in, .rst_n_in,
	.paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .pstrb_in,
	.prdata_out, .pready_out, .pslverr_out, .fas_checked_in,
	.fas_errored_in, .crc4_error_in, .link_message_kind_in,
	.frame_loss_defect_out, .irq_out);

// >>> verification/efh_irq_top_test.sv
// Self-checking bench for the framer and data-link event block.
`timescale 1ns/10ps
module efh_irq_top_test;
	logic        core_clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
	logic [15:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, q;
	logic [3:0]  pstrb_in;
	logic        pready_out, pslverr_out, err, irq_out;
	logic        link_message_kind_in, link_bit_valid_in, link_bit_in;
	logic        frame_loss_defect_out;
	logic [9:0]  evt;
	int          error_cnt, samples_checked, cyc;
	localparam logic [31:0] ONE = 32'h0000_0001;
	efh_irq_top efh_irq_top_i (.core_clk_in, .rst_n_in, .paddr_in, .psel_in,
		.penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .prdata_out,
		.pready_out, .pslverr_out, .fas_checked_in(evt[8]),
		.fas_errored_in(evt[9]), .frame_mimic_in(evt[0]),
		.crc4_error_in(evt[1]), .tx_message_started_in(evt[2]),
		.rx_message_started_in(evt[3]), .tx_message_finished_in(evt[4]),
		.rx_message_finished_in(evt[5]), .rx_buffer_full_in(evt[6]),
		.fcs_error_in(evt[7]), .link_message_kind_in, .link_bit_valid_in,
		.link_bit_in, .frame_loss_defect_out, .irq_out);
	always #4 core_clk_in = ~core_clk_in;
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// The slave answers when it will; only the cycle ceiling ends a wait.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		psel_in   <= 1'b1;
		pwrite_in <= w;
		paddr_in  <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		@(posedge core_clk_in);
		while (pready_out !== 1'b1) @(posedge core_clk_in);
		q = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task rd(input logic [15:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, q);
	endtask : rd
	task ev(input logic [9:0] m);
		@(posedge core_clk_in);
		evt <= m;
		@(posedge core_clk_in);
		evt <= 10'h000;
		repeat (2) @(posedge core_clk_in);
	endtask : ev
	task bits(input logic [7:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge core_clk_in);
			link_bit_valid_in <= 1'b1;
			link_bit_in       <= v[i];
		end
		@(posedge core_clk_in);
		link_bit_valid_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
	endtask : bits
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		apb(1'b1, efh_pkg::FRAMER_STATUS_ADDR, 32'h0000_00FF);
		rd(efh_pkg::FRAMER_STATUS_ADDR, 32'h0000_0000, "fr_st");
		rd(efh_pkg::FRAMER_MASK_ADDR, 32'h0000_0000, "fr_mask");
		rd(efh_pkg::LINK1_MASK_ADDR, 32'h0000_0000, "lk_mask");
		rd(efh_pkg::FRAMER_CTRL_ADDR, 32'h0000_0003, "crit");
		rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0000, "lk_st");
		rd(16'h0B00, 32'h0000_0000, "unmapped");
		chk("slverr", ONE, {31'h0, err});
		$display("t_reset done");
	endtask : t_reset
	task t_masks;
		apb(1'b1, efh_pkg::FRAMER_MASK_ADDR, 32'h0000_00FF);
		rd(efh_pkg::FRAMER_MASK_ADDR, 32'h0000_000F, "fr_mask");
		apb(1'b1, efh_pkg::LINK1_MASK_ADDR, 32'h0000_00FF);
		rd(efh_pkg::LINK1_MASK_ADDR, 32'h0000_0078, "lk_mask");
		pstrb_in <= 4'h0;
		apb(1'b1, efh_pkg::FRAMER_MASK_ADDR, 32'h0000_0000);
		rd(efh_pkg::FRAMER_MASK_ADDR, 32'h0000_000F, "no_strb");
		pstrb_in <= 4'hF;
		apb(1'b1, efh_pkg::FRAMER_MASK_ADDR, 32'h0000_0000);
		rd(efh_pkg::FRAMER_MASK_ADDR, 32'h0000_0000, "fr_mask0");
		$display("t_masks done");
	endtask : t_masks
	// The mimic, CRC-4 and alignment events are each seen first with the enable off, then on.
	task t_framer;
		logic [9:0] m [3];
		logic [31:0] b [3];
		m = '{10'h001, 10'h002, 10'h300};
		b = '{32'h0000_0004, 32'h0000_0002, 32'h0000_0001};
		for (int k = 0; k < 3; k++) begin
			ev(m[k]);
			chk("irq_off", 32'h0000_0000, {31'h0, irq_out});
			rd(efh_pkg::FRAMER_STATUS_ADDR, b[k], "fr_st");
			rd(efh_pkg::FRAMER_STATUS_ADDR, 32'h0000_0000, "fr_clr");
			apb(1'b1, efh_pkg::FRAMER_MASK_ADDR, b[k]);
			ev(m[k]);
			chk("irq_on", ONE, {31'h0, irq_out});
			rd(efh_pkg::FRAMER_STATUS_ADDR, b[k], "fr_st2");
			repeat (2) @(posedge core_clk_in);
			chk("irq_fall", 32'h0000_0000, {31'h0, irq_out});
			apb(1'b1, efh_pkg::FRAMER_MASK_ADDR, 32'h0000_0000);
		end
		chk("no_loss", 32'h0000_0000, {31'h0, frame_loss_defect_out});
		$display("t_framer done");
	endtask : t_framer
	task t_link;
		logic [9:0] m [6];
		logic [31:0] b [6];
		m = '{10'h004, 10'h008, 10'h010, 10'h020, 10'h040, 10'h080};
		b = '{32'h0000_0040, 32'h0000_0020, 32'h0000_0010, 32'h0000_0008,
			32'h0000_0008, 32'h0000_0004};
		apb(1'b1, efh_pkg::LINK1_MASK_ADDR, 32'h0000_0078);
		for (int k = 0; k < 6; k++) begin
			ev(m[k]);
			chk("lk_irq", (k < 5) ? ONE : 32'h0000_0000, {31'h0, irq_out});
			rd(efh_pkg::LINK1_STATUS_ADDR, b[k], "lk_st");
			rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0000, "lk_clr");
		end
		apb(1'b1, efh_pkg::LINK1_MASK_ADDR, 32'h0000_0000);
		$display("t_link done");
	endtask : t_link
	task t_kind;
		link_message_kind_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0080, "kind1");
		link_message_kind_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0000, "kind0");
		$display("t_kind done");
	endtask : t_kind
	// Six ones inside the flag must not count as an abort.
	task t_bits;
		bits(8'h7E, 8);
		rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0001, "idle");
		bits(8'h7F, 7);
		rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0002, "abort");
		bits(8'h7E, 8);
		ev(10'h020);
		rd(efh_pkg::LINK1_STATUS_ADDR, 32'h0000_0009, "whole");
		$display("t_bits done");
	endtask : t_bits
	task t_loss;
		apb(1'b1, efh_pkg::FRAMER_CTRL_ADDR, 32'h0000_0002);
		apb(1'b1, efh_pkg::FRAMER_MASK_ADDR, 32'h0000_0008);
		// A clean pattern first drops the errored run left by t_framer.
		ev(10'h100);
		ev(10'h300);
		repeat (2) @(posedge core_clk_in);
		chk("loss_early", 32'h0000_0000, {31'h0, frame_loss_defect_out});
		ev(10'h300);
		repeat (2) @(posedge core_clk_in);
		chk("loss", ONE, {31'h0, frame_loss_defect_out});
		chk("loss_irq", ONE, {31'h0, irq_out});
		rd(efh_pkg::FRAMER_STATUS_ADDR, 32'h0000_0009, "loss_st");
		ev(10'h100);
		repeat (2) @(posedge core_clk_in);
		chk("regain", 32'h0000_0000, {31'h0, frame_loss_defect_out});
		rd(efh_pkg::FRAMER_STATUS_ADDR, 32'h0000_0008, "regain_st");
		$display("t_loss done");
	endtask : t_loss
	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			end_of_test;
		end
	end
	initial begin
		core_clk_in = 1'b0;
		rst_n_in = 1'b0;
		{psel_in, penable_in, pwrite_in, link_bit_valid_in} = 4'h0;
		{link_bit_in, link_message_kind_in} = 2'h0;
		paddr_in = 16'h0000;
		pwdata_in = 32'h0000_0000;
		pstrb_in = 4'hF;
		evt = 10'h000;
		repeat (20) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		t_reset;
		t_masks;
		t_framer;
		t_link;
		t_kind;
		t_bits;
		t_loss;
		end_of_test;
	end
endmodule : efh_irq_top_test
